/* File: src/uid_eeprom_defs.vh */
// constants for the two-wire eeprom slave with identity area
// assumes a 100 MHz system clock sampling the bus lines
`ifndef UID_EEPROM_DEFS_VH
`define UID_EEPROM_DEFS_VH
`define CTRL_CODE          4'hA
`define PROT_BASE          8'h80
`define MFR_ADDR           8'hFA
`define DEV_ADDR           8'hFB
`define SERIAL_BASE        8'hFC
`define FILTER_LEN         3'h1
`define WRITE_TIME_US      3000
`define CLK_MHZ            100
`define PAGE_MASK          8'h07
`define MEM_DEPTH          256
`endif

/* File: src/uid_eeprom_slave.v */
// two-wire serial eeprom slave: polling, reads, page writes, identity bytes
// assumes scl/sda arrive asynchronously; sda is open drain (oe high pulls low)
// Functional notes
// R1 - no acknowledge to any control byte while the write cycle runs
// R2 - master may poll right after the write stop
// R3 - master polls with start plus write control byte until acknowledged
// R4 - after the write cycle ends the control byte is acknowledged again
// R5 - read control byte has direction bit set to one
// R6 - address counter holds last accessed address plus one
// R7 - read control byte alone is acknowledged, then byte at counter sent
// R8 - unacknowledged read byte ends the read and releases the data line
// R9 - random read: write control byte, address, then repeated start
// R10 - repeated start after address loads pointer and stores nothing
// R11 - read control byte after repeated start sends byte at new address
// R12 - acknowledged read byte is followed by the next sequential byte
// R13 - pointer increments by one after every byte operation; in writes it wraps within the eight-byte page
// R14 - low supply blocks all erase and write activity
// R15 - serial number in upper half is never changed by bus writes
// R16 - lower 1,024 bits are freely readable and writable
// R17 - serial number bytes sit at 0xFC to 0xFF
// R18 - fixed manufacturer code at 0xFA, device code at 0xFB
// R19 - master may read from lower start for longer identifier
// R20 - respond only to control code 1010; lsb selects direction
// R21 - chip select bits must match chip select pins
// R22 - writes to 80h-FFh ignored, reads normal
// R23 - write cycle starts on the stop ending a write
// R24 - pointer wraps from top of array to zero
// R25 - bus lines synchronised and filtered before edge detection
`timescale 1ns/1ns
`include "uid_eeprom_defs.vh"
module uid_eeprom_slave #(
  parameter        WRITE_CYCLES = `WRITE_TIME_US * `CLK_MHZ,
  parameter [7:0]  MFR_CODE     = 8'h5A,        // arbitrary value
  parameter [7:0]  DEV_CODE     = 8'hC3,        // arbitrary value
  parameter [31:0] SERIAL_NUM   = 32'h0BADF00D  // arbitrary value
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  input  wire       chip_select_bit_two_i,
  input  wire       chip_select_bit_one_i,
  input  wire       chip_select_bit_zero_i,
  input  wire       supply_low_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  output reg        write_busy_o
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_CTRL = 3'h1;
  localparam [2:0] S_ADDR = 3'h2;
  localparam [2:0] S_WDAT = 3'h3;
  localparam [2:0] S_RDAT = 3'h4;
  localparam [2:0] S_RACK = 3'h5;

  reg  [7:0]  mem [0:`MEM_DEPTH-1];
  reg  [7:0]  page_buf [0:7];
  reg  [7:0]  page_vld_reg;
  reg  [1:0]  scl_sync_reg;
  reg  [1:0]  sda_sync_reg;
  reg  [2:0]  scl_cnt_reg;
  reg  [2:0]  sda_cnt_reg;
  reg         scl_f_reg;
  reg         sda_f_reg;
  reg  [1:0]  low_sync_reg;
  reg  [2:0]  cs_meta_reg;
  reg  [2:0]  cs_sync_reg;
  reg  [2:0]  state_reg;
  reg  [3:0]  bit_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  ptr_reg;
  reg  [7:0]  base_reg;
  reg         ack_phase_reg;
  reg         drive_low_reg;
  reg  [31:0] wcnt_reg;
  reg         commit_reg;
  reg  [3:0]  commit_idx_reg;
  integer     i;

  function [7:0] read_byte;
    input [7:0] a;
    input [7:0] m;
    begin
      if (a == `MFR_ADDR)
        read_byte = MFR_CODE;                                          // R18
      else if (a == `DEV_ADDR)
        read_byte = DEV_CODE;                                          // R18
      else if (a >= `SERIAL_BASE)
        read_byte = SERIAL_NUM[8'd31 - {a[1:0], 3'h0} -: 8];           // R17
      else
        read_byte = m;
    end
  endfunction

  // two flops on each input line, then a glitch filter on scl and sda only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      low_sync_reg <= 2'h3;
      cs_meta_reg  <= 3'h0;
      cs_sync_reg  <= 3'h0;
      scl_cnt_reg  <= 3'h0;
      sda_cnt_reg  <= 3'h0;
      scl_f_reg    <= 1'b1;
      sda_f_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};                         // R25
      sda_sync_reg <= {sda_sync_reg[0], sda_i};                         // R25
      low_sync_reg <= {low_sync_reg[0], supply_low_i};                  // R14
      cs_meta_reg  <= {chip_select_bit_two_i, chip_select_bit_one_i, chip_select_bit_zero_i};
      cs_sync_reg  <= cs_meta_reg;                                      // R21
      if (scl_sync_reg[1] == scl_f_reg)
        scl_cnt_reg <= 3'h0;
      else if (scl_cnt_reg == `FILTER_LEN)
      begin
        scl_f_reg   <= scl_sync_reg[1];                                 // R25
        scl_cnt_reg <= 3'h0;
      end
      else
        scl_cnt_reg <= scl_cnt_reg + 3'h1;
      if (sda_sync_reg[1] == sda_f_reg)
        sda_cnt_reg <= 3'h0;
      else if (sda_cnt_reg == `FILTER_LEN)
      begin
        sda_f_reg   <= sda_sync_reg[1];
        sda_cnt_reg <= 3'h0;
      end
      else
        sda_cnt_reg <= sda_cnt_reg + 3'h1;
    end
  end

  wire scl_new  = (scl_sync_reg[1] != scl_f_reg) && (scl_cnt_reg == `FILTER_LEN);
  wire sda_new  = (sda_sync_reg[1] != sda_f_reg) && (sda_cnt_reg == `FILTER_LEN);
  wire scl_rise = scl_new && !scl_f_reg;
  wire scl_fall = scl_new && scl_f_reg;
  wire start_ev = sda_new && sda_f_reg && scl_f_reg && !scl_new;        // R25
  wire stop_ev  = sda_new && !sda_f_reg && scl_f_reg && !scl_new;       // R25
  wire [7:0] rx_byte = {shift_reg[6:0], sda_f_reg};
  // checked on the fall after the eighth rise, when shift_reg holds the whole byte
  wire ctrl_ok = (shift_reg[7:4] == `CTRL_CODE) && (shift_reg[3:1] == cs_sync_reg); // R20 R21
  wire [7:0] rd_byte = read_byte(ptr_reg, mem[ptr_reg]);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg      <= S_IDLE;
      bit_reg        <= 4'h0;
      shift_reg      <= 8'h00;
      ptr_reg        <= 8'h00;
      base_reg       <= 8'h00;
      ack_phase_reg  <= 1'b0;
      drive_low_reg  <= 1'b0;
      page_vld_reg   <= 8'h00;
      wcnt_reg       <= 32'h0;
      commit_reg     <= 1'b0;
      commit_idx_reg <= 4'h0;
      sda_o          <= 1'b0;
      sda_oe_o       <= 1'b0;
      write_busy_o   <= 1'b0;
    end
    else
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= drive_low_reg;
      write_busy_o <= (wcnt_reg != 32'h0);
      // self-timed write: copy latched page bytes into the array
      if (commit_reg)
      begin
        if (page_vld_reg[commit_idx_reg[2:0]] && !low_sync_reg[1])    // R14
          mem[{base_reg[7:3], commit_idx_reg[2:0]}] <= page_buf[commit_idx_reg[2:0]];
        if (commit_idx_reg == 4'h7)
        begin
          commit_reg   <= 1'b0;
          page_vld_reg <= 8'h00;
        end
        commit_idx_reg <= commit_idx_reg + 4'h1;
      end
      if (wcnt_reg != 32'h0)
        wcnt_reg <= wcnt_reg - 32'h1;
      if (start_ev)
      begin
        state_reg     <= S_CTRL;                                        // R10
        bit_reg       <= 4'h0;
        ack_phase_reg <= 1'b0;
        drive_low_reg <= 1'b0;
        page_vld_reg  <= commit_reg ? page_vld_reg : 8'h00;             // R10
      end
      else if (stop_ev)
      begin
        if (state_reg == S_WDAT && page_vld_reg != 8'h00 && wcnt_reg == 32'h0)
        begin
          wcnt_reg       <= WRITE_CYCLES;                               // R23
          commit_reg     <= 1'b1;
          commit_idx_reg <= 4'h0;
        end
        state_reg     <= S_IDLE;
        drive_low_reg <= 1'b0;                                          // R8
      end
      else if (state_reg != S_IDLE && scl_rise && !ack_phase_reg)
      begin
        shift_reg <= rx_byte;
        bit_reg   <= (state_reg == S_RACK) ? 4'h0 : bit_reg + 4'h1;    // R12
        if (state_reg == S_RACK)
          state_reg <= sda_f_reg ? S_IDLE : S_RDAT;                     // R8 R12
      end
      else if (state_reg != S_IDLE && scl_fall)
      begin
        if (ack_phase_reg)
        begin
          ack_phase_reg <= 1'b0;
          bit_reg       <= 4'h0;
          drive_low_reg <= 1'b0;
          if (state_reg == S_RDAT)
          begin
            drive_low_reg <= ~rd_byte[7];                               // R7 R11
          end
        end
        else if (state_reg == S_RDAT && bit_reg != 4'h8)
          drive_low_reg <= ~rd_byte[3'h7 - bit_reg[2:0]];
        else if (bit_reg == 4'h8)
        begin
          bit_reg <= 4'h0;
          case (state_reg)
            S_CTRL:
            begin
              if (ctrl_ok && wcnt_reg == 32'h0)                         // R1 R4
              begin
                drive_low_reg <= 1'b1;
                ack_phase_reg <= 1'b1;
                state_reg     <= shift_reg[0] ? S_RDAT : S_ADDR;        // R7 R11
              end
              else
                state_reg <= S_IDLE;                                    // R1
            end
            S_ADDR:
            begin
              ptr_reg       <= shift_reg;                               // R10
              base_reg      <= shift_reg;
              drive_low_reg <= 1'b1;
              ack_phase_reg <= 1'b1;
              state_reg     <= S_WDAT;
            end
            S_WDAT:
            begin
              if (ptr_reg < `PROT_BASE)                                 // R15 R16 R22
              begin
                page_buf[ptr_reg[2:0]]     <= shift_reg;
                page_vld_reg[ptr_reg[2:0]] <= 1'b1;
              end
              ptr_reg       <= (ptr_reg & ~`PAGE_MASK) | ((ptr_reg + 8'h01) & `PAGE_MASK);
              drive_low_reg <= 1'b1;
              ack_phase_reg <= 1'b1;
            end
            S_RDAT:
            begin
              ptr_reg       <= ptr_reg + 8'h01;                         // R6 R13 R24
              drive_low_reg <= 1'b0;
              state_reg     <= S_RACK;
            end
            default: state_reg <= S_IDLE;
          endcase
        end
      end
    end
  end

  initial
  begin
    for (i = 0; i < `MEM_DEPTH; i = i + 1)
      mem[i] = 8'hFF;
  end
endmodule // uid_eeprom_slave

/* File: dv/uid_eeprom_chk.sv */
// assertions on the eeprom slave ports
// assumes one clock domain; bound from the bench top file
`timescale 1ns/1ns
module uid_eeprom_chk #(
  parameter WRITE_CYCLES = 50
) (
  input wire clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire write_busy_o
);
  integer busy_cnt;
  always @(posedge clk_i)
    busy_cnt <= (rst_i || !write_busy_o) ? 0 : busy_cnt + 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; disable iff (1'b0) rst_i |=> !sda_oe_o && !write_busy_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_busy_quiet; write_busy_o |-> !sda_oe_o; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive in write cycle");
  property p_busy_start; $rose(write_busy_o) |-> scl_i && sda_i; endproperty
  a_busy_start: assert property (p_busy_start) else $error("write cycle not at stop");
  property p_busy_len; $fell(write_busy_o) |-> busy_cnt >= WRITE_CYCLES - 2; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle too short");
  property p_busy_max; write_busy_o |-> busy_cnt <= WRITE_CYCLES + 1; endproperty
  a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
  property p_stands; $rose(sda_oe_o) |=> sda_oe_o [*8]; endproperty
  a_stands: assert property (p_stands) else $error("drive shorter than a bit");
  property p_no_restart; $fell(write_busy_o) |=> !write_busy_o [*8]; endproperty
  a_no_restart: assert property (p_no_restart) else $error("write cycle restarted");
  property p_open_drain; sda_oe_o |-> !sda_o; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");
endmodule // uid_eeprom_chk

/* File: dv/two_wire_master.sv */
// two-wire bus master model: bit-banged link clock of 125 ns period
// assumes the data wire is pulled up; sda_oe_o high pulls it low
`timescale 1ns/1ns
module two_wire_master (
  input  wire       sda_i,
  output reg        scl_o    = 1'b1,
  output reg        sda_oe_o = 1'b0,
  output reg  [8:0] res_o    = 9'h000,
  output reg        done_o   = 1'b0
);
  reg r;
  task bit_io(input b);
  begin
    scl_o = 1'b0;
    #31 sda_oe_o = !b;
    #32 scl_o = 1'b1;
    #62 r = sda_i;
  end
  endtask
  // start or repeated start, data falls while clock high
  task start_c;
  begin
    bit_io(1'b1);
    sda_oe_o = 1'b1;
    #65;
  end
  endtask
  task stop_c;
  begin
    bit_io(1'b0);
    sda_oe_o = 1'b0;
    #65;
  end
  endtask
  // eight bits msb first, then the acknowledge slot; 1 releases the line
  task byte_io(input [7:0] tx, input mack);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_io(tx[i]);
      res_o[i] = r;
    end
    bit_io(mack);
    res_o[8] = r;
    done_o = !done_o;
  end
  endtask
endmodule // two_wire_master

/* File: dv/uid_eeprom_slave_tb_top.sv */
// self-checking bench for the two-wire eeprom slave
// assumes the master model drives the link; results checked from a queue
`timescale 1ns/1ns
module uid_eeprom_slave_tb_top;
  localparam WC = 400;
  localparam [7:0] MFR = 8'h6E; // arbitrary value
  localparam [7:0] DEV = 8'h17; // arbitrary value
  localparam [31:0] SER = 32'h13579BDF; // arbitrary value
  reg        clk_i = 1'b0;
  reg        rst_i = 1'b1;
  reg  [2:0] cs = 3'h0;
  reg        supply_low = 1'b0;
  wire       scl, sda, sda_o, dev_oe, mst_oe, busy, done;
  wire [8:0] res;
  reg  [9:0] expq[$];
  reg  [9:0] x;
  reg  [31:0] r;
  reg  [7:0] a, e;
  integer    n_errors = 0;
  integer    checked = 0;
  integer    k;
  assign sda = !(dev_oe || mst_oe);
  always #5 clk_i = !clk_i;
  uid_eeprom_slave #(.WRITE_CYCLES(WC), .MFR_CODE(MFR), .DEV_CODE(DEV), .SERIAL_NUM(SER))
    uid_eeprom_slave_inst (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .chip_select_bit_two_i(cs[2]), .chip_select_bit_one_i(cs[1]),
    .chip_select_bit_zero_i(cs[0]), .supply_low_i(supply_low), .sda_o(sda_o),
    .sda_oe_o(dev_oe), .write_busy_o(busy));
  two_wire_master two_wire_master_inst (.sda_i(sda), .scl_o(scl), .sda_oe_o(mst_oe),
    .res_o(res), .done_o(done));
  task final_report;
  begin
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task chk_byte(input [7:0] ex, input [7:0] got);
  begin
    checked = checked + 1;
    if (got !== ex)
    begin
      n_errors = n_errors + 1;
      $display("ERROR %0t exp %h got %h", $time, ex, got);
    end
  end
  endtask
  task chk_ack(input ex, input got);
    chk_byte({7'h00, ex}, {7'h00, got});
  endtask
  always @(done)
  begin
    x = expq.pop_front();
    chk_ack(x[8], res[8]);
    if (x[9])
      chk_byte(x[7:0], res[7:0]);
  end
  function [7:0] ctl(input rw); ctl = {4'hA, cs, rw}; endfunction
  // wait, then step off the clock edge so link changes never meet a sampling edge
  task idle(input integer n);
  begin
    repeat (n) @(posedge clk_i);
    #1;
  end
  endtask
  task st; two_wire_master_inst.start_c; endtask
  task sp; two_wire_master_inst.stop_c; endtask
  task xb(input [7:0] tx, input mack, input [9:0] ex);
  begin
    expq.push_back(ex);
    two_wire_master_inst.byte_io(tx, mack);
  end
  endtask
  initial
  begin
    #300000;
    n_errors = n_errors + 1;
    final_report;
  end
  initial
  begin
    r = $urandom(32'hDDAC0350);
    repeat (20) @(posedge clk_i);
    r = $urandom;
    rst_i <= 1'b0;
    cs <= r[2:0];
    idle(10);
    st; xb(ctl(0), 1, 10'h000); xb(8'h16, 1, 10'h000);
    xb(r[15:8], 1, 10'h000); xb(r[23:16], 1, 10'h000); sp;
    st; xb(ctl(0), 1, 10'h100); sp;
    idle(WC + 20);
    st; xb(ctl(0), 1, 10'h000); xb(8'h16, 1, 10'h000); st;
    xb(ctl(1), 1, 10'h000); xb(8'hFF, 0, {2'b10, r[15:8]});
    xb(8'hFF, 1, {2'b11, r[23:16]}); sp;
    st; xb(ctl(1), 1, 10'h000); xb(8'hFF, 1, 10'h3FF); sp;
    for (k = 0; k < 2; k = k + 1)
    begin
      supply_low <= k[0];
      st; xb(ctl(0), 1, 10'h000); xb(k ? 8'h05 : 8'hFC, 1, 10'h000);
      xb(8'h00, 1, 10'h000); sp;
      idle(WC + 20);
    end
    supply_low <= 1'b0;
    st; xb(ctl(0), 1, 10'h000); xb(8'hFA, 1, 10'h000); st; xb(ctl(1), 1, 10'h000);
    for (k = 0; k < 12; k = k + 1)
    begin
      a = 8'hFA + k[7:0];
      e = (a == 8'hFA) ? MFR : (a == 8'hFB) ? DEV :
          (a >= 8'hFC) ? SER >> (8 * (8'hFF - a)) : 8'hFF;
      xb(8'hFF, k == 11, {1'b1, k == 11, e});
    end
    sp;
    st; xb({4'hB, cs, 1'b0}, 1, 10'h100); sp;
    st; xb({4'hA, ~cs, 1'b0}, 1, 10'h100); sp;
    repeat (20) @(posedge clk_i);
    final_report;
  end
endmodule // uid_eeprom_slave_tb_top
bind uid_eeprom_slave uid_eeprom_chk #(.WRITE_CYCLES(WRITE_CYCLES)) uid_eeprom_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .write_busy_o(write_busy_o));
